// ---- bench/rtcxp_host_model.sv ----
/* Processor on the parallel bus: byte reads and writes by task call.
   Assumes the bench resolves the data wire from both drivers. */
`timescale 1ns/10ps
module rtcxp_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_bus,
    input  wire logic       i_dev_oe,
    output logic            o_rtc_sel_n,
    output logic            o_ram_sel_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic [5:0]      o_addr,
    output logic [7:0]      o_dat,
    output logic            o_dat_oe
);
    // Bus idle at time zero
    initial begin
        {o_rtc_sel_n, o_ram_sel_n, o_rd_n, o_wr_n} = 4'hf;
        {o_addr, o_dat, o_dat_oe} = 15'h0000;
    end

    task automatic open_cycle(input logic ram, input logic [5:0] a);
        @(posedge i_clk);
        o_rtc_sel_n <= ram;
        o_ram_sel_n <= !ram;
        o_addr      <= a;
    endtask

    // Release everything, then keep the bus quiet two cycles
    task automatic close_cycle();
        o_rtc_sel_n <= 1'b1;
        o_ram_sel_n <= 1'b1;
        o_dat_oe    <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask

    // Strobe held low two cycles; select held past the rising strobe
    task automatic wr(input logic ram, input logic [5:0] a, input logic [7:0] d);
        open_cycle(ram, a);
        o_dat    <= d;
        o_dat_oe <= 1'b1;
        o_wr_n   <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_wr_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        close_cycle();
    endtask

    // Data taken well after the device starts driving; ok tells if it drove
    task automatic rd(input logic ram, input logic [5:0] a, output logic [7:0] d,
                      output logic ok);
        open_cycle(ram, a);
        o_rd_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        d  = i_bus;
        ok = i_dev_oe;
        o_rd_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        close_cycle();
    endtask
endmodule

// ---- bench/rtcxp_port_checker.sv ----
/* Concurrent checks on the host port pins and the register bus handshake.
   Assumes binding onto rtcxp_port; one clock, reset active low. */
`timescale 1ns/10ps
module rtcxp_port_checker (
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic       i_rtc_select_n,
    input wire logic       i_extended_ram_select_n,
    input wire logic       i_rd_n,
    input wire logic       i_wr_n,
    input wire logic [5:0] i_addr,
    input wire logic       i_standby_n,
    input wire logic       i_reset_pin_n,
    input wire logic       o_data_oe,
    input wire logic       o_irq_n,
    input wire logic       o_irq_oe,
    input wire logic       o_square_wave_out,
    input wire logic       i_wb_cyc,
    input wire logic       i_wb_stb,
    input wire logic       o_wb_ack
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    // Steady RAM read long enough for the drive to have started
    sequence s_ram_rd;
        (i_rtc_select_n && !i_extended_ram_select_n && !i_rd_n && i_wr_n
         && i_standby_n && $stable(i_addr))[*3];
    endsequence

    AST_DRIVE_CAUSE: assert property (o_data_oe |->
        $past(!i_rd_n && (!i_rtc_select_n || !i_extended_ram_select_n)))
        else $error("data bus driven without a selected read");
    AST_RAM_READ: assert property (s_ram_rd |-> o_data_oe)
        else $error("selected RAM read not driven");
    AST_STANDBY_N_FLOAT: assert property (!i_standby_n[*2] |-> !o_data_oe && !o_irq_oe)
        else $error("output driven during standby");
    AST_IRQ_POLARITY: assert property (o_irq_oe != o_irq_n)
        else $error("interrupt pin value and enable disagree");
    AST_RSTPIN_IRQ: assert property (!i_reset_pin_n[*2] |-> !o_irq_oe)
        else $error("interrupt pin pulled during reset pin");
    AST_RSTPIN_REFUSE: assert property (
        (!i_reset_pin_n && i_extended_ram_select_n)[*2] |-> !o_data_oe)
        else $error("clock bank driven during reset pin");
    AST_RSTPIN_SQW: assert property (!i_reset_pin_n[*3] |-> !o_square_wave_out)
        else $error("square wave running during reset pin");
    AST_WB_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("acknowledge longer than one cycle");
    AST_WB_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("acknowledge not in the next cycle");
endmodule

bind rtcxp_port rtcxp_port_checker u_chk (
    .i_clk, .i_resetn, .i_rtc_select_n, .i_extended_ram_select_n, .i_rd_n, .i_wr_n,
    .i_addr, .i_standby_n, .i_reset_pin_n, .o_data_oe, .o_irq_n, .o_irq_oe,
    .o_square_wave_out, .i_wb_cyc, .i_wb_stb, .o_wb_ack);

// ---- bench/rtcxp_port_tb.sv ----
/* Self-checking bench for the clock and extended RAM host port.
   Assumes rtcxp_pkg and the design are compiled first. */
`timescale 1ns/10ps
module rtcxp_port_tb;
    import rtcxp_pkg::*;
    logic        clk, rstn, standby_n_n, rpin_n, cyc, stb, we, ack, wirq;
    logic        d_oe, irq_n, irq_oe, square_wave_out, h_rtc, h_ram, h_rd, h_wr, h_oe, ok;
    logic [2:0]  ev;
    logic [15:0] taps;
    logic [7:0]  adr, d_dat, h_dat, bus_last, q;
    logic [5:0]  h_addr;
    logic [31:0] wdat, rdat;
    int          miscompares, cmp_count;
    wire  [7:0]  bus     = h_oe ? h_dat : (d_oe ? d_dat : ~bus_last);
    wire         irq_pin = !irq_oe;

    rtcxp_port dut (
        .i_clk(clk), .i_resetn(rstn), .i_rtc_select_n(h_rtc),
        .i_extended_ram_select_n(h_ram), .i_rd_n(h_rd), .i_wr_n(h_wr),
        .i_addr(h_addr), .i_data(bus), .o_data(d_dat), .o_data_oe(d_oe),
        .i_standby_n(standby_n_n), .i_reset_pin_n(rpin_n), .o_irq_n(irq_n),
        .o_irq_oe(irq_oe), .o_square_wave_out(square_wave_out), .i_periodic_tick(ev[2]),
        .i_alarm_match(ev[1]), .i_update_done(ev[0]), .i_rate_taps(taps),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_wb_irq(wirq));
    rtcxp_host_model host (
        .i_clk(clk), .i_bus(bus), .i_dev_oe(d_oe), .o_rtc_sel_n(h_rtc),
        .o_ram_sel_n(h_ram), .o_rd_n(h_rd), .o_wr_n(h_wr), .o_addr(h_addr),
        .o_dat(h_dat), .o_dat_oe(h_oe));

    // Undriven wire shows the inverse of its last level
    always @(posedge clk) bus_last <= bus;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle, held until acknowledge; the watchdog bounds the wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic cw(input logic [5:0] i, input logic [7:0] d);
        host.wr(1'b0, 6'h00, {2'b00, i});
        host.wr(1'b0, 6'h01, d);
    endtask

    task automatic cr(input logic [5:0] i, output logic [7:0] q);
        host.wr(1'b0, 6'h00, {2'b00, i});
        host.rd(1'b0, 6'h01, q, ok);
    endtask

    task automatic pulse(input logic [2:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 3'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_index();
        cw(6'h3f, 8'h3c);
        cw(6'h0e, 8'hc3);
        cw(IDX_REG_C, 8'hff);
        cw(IDX_REG_D, 8'h00);
        cr(6'h3f, q);
        chk(q, 8'h3c);
        cr(6'h0e, q);
        chk(q, 8'hc3);
        host.rd(1'b0, 6'h00, q, ok);
        chk(q, 8'h0e);
        cr(IDX_REG_C, q);
        chk(q, 8'h00);
        cr(IDX_REG_D, q);
        chk(q, REG_D_VAL);
    endtask

    // Same byte offset on two pages, page set through aliases
    task automatic t_page();
        host.wr(1'b1, 6'h3f, 8'h7f);
        host.wr(1'b1, 6'h1f, 8'ha5);
        host.wr(1'b1, 6'h20, 8'h00);
        host.wr(1'b1, 6'h1f, 8'h5a);
        host.rd(1'b1, 6'h35, q, ok);
        chk(q, 8'h00);
        host.rd(1'b1, 6'h1f, q, ok);
        chk(q, 8'h5a);
        host.wr(1'b1, 6'h2a, 8'h7f);
        host.rd(1'b1, 6'h1f, q, ok);
        chk(q, 8'ha5);
    endtask

    // Each source with its enable off, then on
    task automatic t_irq();
        for (int i = 0; i < 3; i++) begin
            for (int en = 0; en < 2; en++) begin
                cw(IDX_REG_B, en ? (8'h10 << i) : 8'h00);
                pulse(3'h1 << i);
                chk(irq_pin, !en);
                cr(IDX_REG_C, q);
                chk(q, (en ? 8'h80 : 8'h00) | (8'h10 << i));
                chk(irq_pin, 8'h01);
            end
        end
    endtask

    task automatic t_sqw();
        cw(IDX_REG_B, 8'h08);
        for (int rs = 0; rs < 16; rs++) begin
            cw(IDX_REG_A, 8'(rs));
            taps <= 16'h1 << rs;
            repeat (3) @(posedge clk);
            chk(square_wave_out, rs != 0);
            taps <= ~(16'h1 << rs);
            repeat (3) @(posedge clk);
            chk(square_wave_out, 8'h00);
        end
    endtask

    task automatic t_rpin();
        cw(IDX_REG_B, 8'h78);
        pulse(3'h2);
        chk(irq_pin, 8'h00);
        rpin_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq_pin, 8'h01);
        host.rd(1'b0, 6'h01, q, ok);
        chk(ok, 8'h00);
        rpin_n <= 1'b1;
        cr(IDX_REG_B, q);
        chk(q, 8'h00);
        cr(IDX_REG_C, q);
        chk(q, 8'h00);
    endtask

    task automatic t_standby_n();
        host.wr(1'b1, 6'h05, 8'h11);
        standby_n_n <= 1'b0;
        host.wr(1'b1, 6'h05, 8'hee);
        host.rd(1'b1, 6'h05, q, ok);
        chk(ok, 8'h00);
        standby_n_n <= 1'b1;
        host.rd(1'b1, 6'h05, q, ok);
        chk(q, 8'h11);
    endtask

    // Event raised, masked, cleared; unmapped read; RAM write protect
    task automatic t_wb();
        logic [31:0] q;
        logic [7:0]  b;
        wb(1'b1, WB_CLEAR, 32'hf, q);
        wb(1'b1, WB_ENABLE, 32'h2, q);
        host.wr(1'b1, 6'h06, 8'h42);
        chk(wirq, 8'h01);
        wb(0, WB_STATUS, 32'h0, q);
        chk(q, 8'h02);
        wb(1'b1, WB_ENABLE, 32'h0, q);
        repeat (2) @(posedge clk);
        chk(wirq, 8'h00);
        wb(1'b1, WB_CLEAR, 32'h2, q);
        wb(1'b0, WB_STATUS, 32'h0, q);
        chk(q, 8'h00);
        wb(1'b0, WB_INFO, 32'h0, q);
        chk(q, 32'h0000_7f0c);
        wb(1'b0, 8'h40, 32'h0, q);
        chk(q, 8'h00);
        wb(1'b1, WB_CTRL, 32'h1, q);
        host.wr(1'b1, 6'h06, 8'h99);
        host.rd(1'b1, 6'h06, b, ok);
        chk(b, 8'h42);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Clock of 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Bounded run; a hang counts as a mismatch
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        {rstn, cyc, stb, we, ev, adr, wdat, taps, bus_last} = '0;
        {standby_n_n, rpin_n, miscompares, cmp_count} = {2'b11, 64'h0};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_index();
        t_page();
        t_irq();
        t_sqw();
        t_rpin();
        t_standby_n();
        t_wb();
        print_verdict();
    end
endmodule

// ---- rtl/rtcxp_mem.sv ----
/*
 * Single port byte storage with registered read data.
 * Assumes one clock; contents are not reset, as in nonvolatile storage.
 */
`timescale 1ns/10ps
module rtcxp_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 8
) (
    input  wire logic  i_clk,
    rtcxp_mem_if.mem   bus
);
    logic [DW-1:0] store [DEPTH];
    logic [DW-1:0] rdata_r;

    // Write port and registered read; read shows old data on a write cycle
    always_ff @(posedge i_clk) begin
        if (bus.we) begin
            store[bus.addr] <= bus.wdata;
        end
        rdata_r <= store[bus.addr];
    end

    assign bus.rdata = rdata_r;
endmodule

// ---- rtl/rtcxp_mem_if.sv ----
/*
 * Carrier between the port logic and one storage array.
 * Assumes the owner drives address, write enable and data combinationally.
 */
`timescale 1ns/10ps
interface rtcxp_mem_if #(
    parameter int AW = 6,
    parameter int DW = 8
);
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ---- rtl/rtcxp_pkg.sv ----
/*
 * Shared constants and types for the clock and extended RAM host port.
 * Assumes it is compiled before the interface and modules that import it.
 */
package rtcxp_pkg;

    // Storage sizes
    localparam int CLK_BANK_BYTES = 64;
    localparam int PAGE_COUNT     = 128;
    localparam int PAGE_BYTES     = 32;

    // Clock bank locations with special handling; A, B and C in flip-flops, D constant, seconds in memory
    localparam logic [5:0] IDX_SECONDS = 6'h00;
    localparam logic [5:0] IDX_REG_A   = 6'h0a;
    localparam logic [5:0] IDX_REG_B   = 6'h0b;
    localparam logic [5:0] IDX_REG_C   = 6'h0c;
    localparam logic [5:0] IDX_REG_D   = 6'h0d;

    // Field positions in control register A, B, status C and seconds
    localparam int A_UIP_BIT  = 7;
    localparam int A_RS_LSB   = 0;
    localparam int B_PIE_BIT  = 6;
    localparam int B_AIE_BIT  = 5;
    localparam int B_UIE_BIT  = 4;
    localparam int B_SQUARE_WAVE_ENABLE_BIT = 3;
    localparam int C_INTERRUPT_PENDING_FLAG_BIT = 7;
    localparam int C_PF_BIT   = 6;
    localparam int C_AF_BIT   = 5;
    localparam int C_UF_BIT   = 4;
    localparam int SEC_RO_BIT = 7;

    // Values after reset
    localparam logic [7:0] REG_A_RST = 8'h00;
    localparam logic [7:0] REG_B_RST = 8'h00;
    localparam logic [7:0] REG_D_VAL = 8'h80;
    localparam logic [5:0] INDEX_RST = 6'h00;
    localparam logic [6:0] PAGE_RST  = 7'h00;

    // Wishbone register byte offsets
    localparam logic [7:0] WB_STATUS = 8'h00;
    localparam logic [7:0] WB_ENABLE = 8'h04;
    localparam logic [7:0] WB_CLEAR  = 8'h08;
    localparam logic [7:0] WB_INFO   = 8'h0c;
    localparam logic [7:0] WB_CTRL   = 8'h10;

    // Event bits of the status, enable and clear registers
    localparam int EVT_W         = 4;
    localparam int EVT_CLK_WRITE = 0;
    localparam int EVT_RAM_WRITE = 1;
    localparam int EVT_PAGE_SET  = 2;
    localparam int EVT_ABORT     = 3;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

    // Control register bits
    localparam int CTRL_RAM_WP_BIT = 0;

    typedef enum logic [2:0] {
        TGT_NONE, TGT_INDEX, TGT_DATA, TGT_PAGE, TGT_XBYTE
    } rtcxp_tgt_type;

    typedef enum logic [1:0] {
        ST_IDLE, ST_READ, ST_WRITE
    } rtcxp_state_type;

endpackage

// ---- rtl/rtcxp_port.sv ----
/*
 * Host access port of a real time clock with paged extended RAM.
 * Pin inputs are synchronous to i_clk; timekeeping events and the
 * square wave tap set come from a counting chain outside this block.
 */
// Design decisions made here: register access over Wishbone and the address map.
// Overview of operation
// - Selected write stores bus data at the write strobe rising edge.
// - Data bus driven only while read strobe low and a bank selected.
// - Clock bank: address bit zero picks index or data register.
// - RAM select with address bit five high reaches the page register.
// - Address bit five low: bits zero to four pick page byte.
// - Standby low ignores accesses and floats data and interrupt pins; storage kept.
// - Cycle caught by standby ends at cycle end or select loss.
// - Interrupt pin is open-drain, active low, following pending flag.
// - Alarm, update and periodic flags raise interrupt per their enables.
// - Square wave frequency picked by four rate select bits.
// - Reset pin low clears enables, square wave enable and all flags.
// - Reset pin low keeps interrupt pin floating.
// - Reset pin low refuses clock bank reads and writes.
// - Index register picks one of 64 clock bank locations.
// - Page register picks one of 128 RAM pages.
// - Status registers C and D ignore writes.
`timescale 1ns/10ps
module rtcxp_port #(
    parameter int PAGES = rtcxp_pkg::PAGE_COUNT
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Host parallel bus
    input  wire logic        i_rtc_select_n,
    input  wire logic        i_extended_ram_select_n,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [5:0]  i_addr,
    input  wire logic [7:0]  i_data,
    output logic      [7:0]  o_data,
    output logic             o_data_oe,
    input  wire logic        i_standby_n,
    input  wire logic        i_reset_pin_n,
    output logic             o_irq_n,
    output logic             o_irq_oe,
    output logic             o_square_wave_out,
    // Timekeeping chain
    input  wire logic        i_periodic_tick,
    input  wire logic        i_alarm_match,
    input  wire logic        i_update_done,
    input  wire logic [15:0] i_rate_taps,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_irq
);
    import rtcxp_pkg::*;

    localparam int XAW = $clog2(PAGES * PAGE_BYTES);

    rtcxp_mem_if #(.AW(6),   .DW(8)) clk_mem ();
    rtcxp_mem_if #(.AW(XAW), .DW(8)) ram_mem ();

    rtcxp_state_type     state_r,  state_nxt;
    rtcxp_tgt_type       tgt_r,    tgt_nxt;
    rtcxp_tgt_type       tgt_now;
    logic [7:0]          data_q_r;
    logic                commit;
    logic                abort;
    logic                start_ok;
    logic                c_read_done;
    logic [5:0]          index_r,  index_nxt;
    logic [6:0]          page_r,   page_nxt;
    logic [7:0]          reg_a_r,  reg_a_nxt;
    logic [7:0]          reg_b_r,  reg_b_nxt;
    logic [3:0]          flags_r,  flags_nxt;
    logic                interrupt_pending_flag;
    logic [7:0]          rd_data;
    logic [7:0]          data_r,   data_nxt;
    logic                data_oe_r, data_oe_nxt;
    logic                irq_drv_r, irq_drv_nxt;
    logic                sqw_r,    sqw_nxt;
    logic [EVT_W-1:0]    status_r, status_nxt;
    logic [EVT_W-1:0]    enable_r, enable_nxt;
    logic                ctrl_wp_r, ctrl_wp_nxt;
    logic                ack_r,    ack_nxt;
    logic [31:0]         wb_dat_r, wb_dat_nxt;
    logic                wb_irq_r, wb_irq_nxt;
    logic [EVT_W-1:0]    events;
    logic                wb_wr;

    // Bank and register decode from the select lines and address
    function automatic rtcxp_tgt_type decode(input logic rtc_n, input logic ram_n,
                                             input logic [5:0] a);
        if (!rtc_n) begin
            return a[0] ? TGT_DATA : TGT_INDEX;
        end else if (!ram_n) begin
            return a[5] ? TGT_PAGE : TGT_XBYTE;
        end
        return TGT_NONE;
    endfunction

    function automatic logic is_clk_bank(input rtcxp_tgt_type t);
        return (t == TGT_INDEX) || (t == TGT_DATA);
    endfunction

    assign tgt_now  = decode(i_rtc_select_n, i_extended_ram_select_n, i_addr);
    assign start_ok = i_standby_n && (tgt_now != TGT_NONE) &&
                      !(is_clk_bank(tgt_now) && !i_reset_pin_n);

    // Access sequencer: a cycle already running survives standby until it
    // ends or its select goes away, so a write is never torn in half
    always_comb begin
        state_nxt   = state_r;
        tgt_nxt     = tgt_r;
        commit      = 1'b0;
        abort       = 1'b0;
        c_read_done = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start_ok && !i_rd_n) begin
                    state_nxt = ST_READ;
                    tgt_nxt   = tgt_now;
                end else if (start_ok && !i_wr_n) begin
                    state_nxt = ST_WRITE;
                    tgt_nxt   = tgt_now;
                end
            end
            ST_READ: begin
                // end on cycle end or select loss
                if (tgt_now != tgt_r || (is_clk_bank(tgt_r) && !i_reset_pin_n)) begin
                    state_nxt = ST_IDLE;
                    abort     = 1'b1;
                end else if (i_rd_n) begin
                    state_nxt   = ST_IDLE;
                    c_read_done = (tgt_r == TGT_DATA) && (index_r == IDX_REG_C);
                end
            end
            ST_WRITE: begin
                if (tgt_now != tgt_r || (is_clk_bank(tgt_r) && !i_reset_pin_n)) begin
                    state_nxt = ST_IDLE;
                    abort     = 1'b1;
                end else if (i_wr_n) begin
                    state_nxt = ST_IDLE;
                    commit    = !((tgt_r == TGT_XBYTE) && ctrl_wp_r);
                    abort     = !commit;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Memory hookup; data_q_r is the bus as it stood before the strobe rose
    always_comb begin
        clk_mem.addr  = index_r;
        clk_mem.wdata = (index_r == IDX_SECONDS) ?
                        {clk_mem.rdata[SEC_RO_BIT], data_q_r[6:0]} : data_q_r;
        clk_mem.we    = commit && (tgt_r == TGT_DATA) &&
                        !(index_r inside {IDX_REG_A, IDX_REG_B, IDX_REG_C, IDX_REG_D});
        ram_mem.addr  = XAW'({page_r, i_addr[4:0]});
        ram_mem.wdata = data_q_r;
        ram_mem.we    = commit && (tgt_r == TGT_XBYTE);
    end

    // Pointer and control register updates
    always_comb begin
        index_nxt = index_r;
        page_nxt  = page_r;
        reg_a_nxt = reg_a_r;
        reg_b_nxt = reg_b_r;
        if (commit) begin
            case (tgt_r)
                TGT_INDEX: begin
                    index_nxt = data_q_r[5:0];
                end
                TGT_PAGE: begin
                    page_nxt = data_q_r[6:0];
                end
                TGT_DATA: begin
                    if (index_r == IDX_REG_A) begin
                        reg_a_nxt = {reg_a_r[A_UIP_BIT], data_q_r[6:0]};
                    end else if (index_r == IDX_REG_B) begin
                        reg_b_nxt = data_q_r;
                    end
                end
                default: begin
                    index_nxt = index_r;
                end
            endcase
        end
        if (!i_reset_pin_n) begin
            reg_b_nxt[B_PIE_BIT]  = 1'b0;
            reg_b_nxt[B_AIE_BIT]  = 1'b0;
            reg_b_nxt[B_UIE_BIT]  = 1'b0;
            reg_b_nxt[B_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
        end
    end

    // Interrupt flags in C[6:4]; reading C clears them but a new event wins
    always_comb begin
        flags_nxt = flags_r;
        if (c_read_done) begin
            flags_nxt = 4'h0;
        end
        if (i_periodic_tick) begin
            flags_nxt[C_PF_BIT-4] = 1'b1;
        end
        if (i_alarm_match) begin
            flags_nxt[C_AF_BIT-4] = 1'b1;
        end
        if (i_update_done) begin
            flags_nxt[C_UF_BIT-4] = 1'b1;
        end
        flags_nxt[C_INTERRUPT_PENDING_FLAG_BIT-4] = (flags_nxt[C_PF_BIT-4] && reg_b_nxt[B_PIE_BIT]) ||
                                  (flags_nxt[C_AF_BIT-4] && reg_b_nxt[B_AIE_BIT]) ||
                                  (flags_nxt[C_UF_BIT-4] && reg_b_nxt[B_UIE_BIT]);
        if (!i_reset_pin_n) begin
            flags_nxt = 4'h0;
        end
    end
    assign interrupt_pending_flag = flags_r[C_INTERRUPT_PENDING_FLAG_BIT-4];

    // Read data selection; memory data arrives one clock after the address
    always_comb begin
        case (tgt_r)
            TGT_INDEX: rd_data = {2'h0, index_r};
            TGT_PAGE:  rd_data = {1'h0, page_r};
            TGT_XBYTE: rd_data = ram_mem.rdata;
            TGT_DATA: begin
                case (index_r)
                    IDX_REG_A: rd_data = reg_a_r;
                    IDX_REG_B: rd_data = reg_b_r;
                    IDX_REG_C: rd_data = {flags_r, 4'h0};
                    IDX_REG_D: rd_data = REG_D_VAL;
                    default:   rd_data = clk_mem.rdata;
                endcase
            end
            default: rd_data = 8'h00;
        endcase
    end

    // Pin drivers
    always_comb begin
        data_oe_nxt = (state_nxt == ST_READ) && (state_r == ST_READ) && i_standby_n;
        data_nxt    = data_oe_nxt ? rd_data : 8'h00;
        irq_drv_nxt = interrupt_pending_flag && i_reset_pin_n && i_standby_n;
        sqw_nxt     = reg_b_r[B_SQUARE_WAVE_ENABLE_BIT] && (reg_a_r[A_RS_LSB+:4] != 4'h0) &&
                      i_rate_taps[reg_a_r[A_RS_LSB+:4]];
    end

    // Wishbone slave: one wait state, ack drops the cycle after it rises
    assign wb_wr  = i_wb_cyc && i_wb_stb && i_wb_we && ack_r && i_wb_sel[0];
    assign events = {EVT_W{1'b0}} |
                    (EVT_W'(commit && tgt_r == TGT_DATA)  << EVT_CLK_WRITE) |
                    (EVT_W'(commit && tgt_r == TGT_XBYTE) << EVT_RAM_WRITE) |
                    (EVT_W'(commit && tgt_r == TGT_PAGE)  << EVT_PAGE_SET)  |
                    (EVT_W'(abort) << EVT_ABORT);
    always_comb begin
        ack_nxt     = i_wb_cyc && i_wb_stb && !ack_r;
        enable_nxt  = enable_r;
        ctrl_wp_nxt = ctrl_wp_r;
        status_nxt  = status_r;
        if (wb_wr && i_wb_adr == WB_CLEAR) begin
            status_nxt = status_r & ~i_wb_dat[EVT_W-1:0];
        end
        status_nxt = status_nxt | events;   // Set wins over clear
        if (wb_wr && i_wb_adr == WB_ENABLE) begin
            enable_nxt = i_wb_dat[EVT_W-1:0];
        end
        if (wb_wr && i_wb_adr == WB_CTRL) begin
            ctrl_wp_nxt = i_wb_dat[CTRL_RAM_WP_BIT];
        end
        wb_dat_nxt = 32'h0000_0000;
        if (ack_nxt && !i_wb_we) begin
            case (i_wb_adr)
                WB_STATUS: wb_dat_nxt = {28'h0, status_r};
                WB_ENABLE: wb_dat_nxt = {28'h0, enable_r};
                WB_INFO:   wb_dat_nxt = {8'h00, flags_r, 4'h0, 1'h0, page_r, 2'h0, index_r};
                WB_CTRL:   wb_dat_nxt = {31'h0, ctrl_wp_r};
                default:   wb_dat_nxt = 32'h0000_0000;
            endcase
        end
        wb_irq_nxt = |(status_r & enable_r);
    end

    // All state registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r   <= ST_IDLE;
            tgt_r     <= TGT_NONE;
            data_q_r  <= 8'h00;
            index_r   <= INDEX_RST;
            page_r    <= PAGE_RST;
            reg_a_r   <= REG_A_RST;
            reg_b_r   <= REG_B_RST;
            flags_r   <= 4'h0;
            data_r    <= 8'h00;
            data_oe_r <= 1'b0;
            irq_drv_r <= 1'b0;
            sqw_r     <= 1'b0;
            status_r  <= EVT_RST;
            enable_r  <= EVT_RST;
            ctrl_wp_r <= 1'b0;
            ack_r     <= 1'b0;
            wb_dat_r  <= 32'h0000_0000;
            wb_irq_r  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            tgt_r     <= tgt_nxt;
            data_q_r  <= i_data;
            index_r   <= index_nxt;
            page_r    <= page_nxt;
            reg_a_r   <= reg_a_nxt;
            reg_b_r   <= reg_b_nxt;
            flags_r   <= flags_nxt;
            data_r    <= data_nxt;
            data_oe_r <= data_oe_nxt;
            irq_drv_r <= irq_drv_nxt;
            sqw_r     <= sqw_nxt;
            status_r  <= status_nxt;
            enable_r  <= enable_nxt;
            ctrl_wp_r <= ctrl_wp_nxt;
            ack_r     <= ack_nxt;
            wb_dat_r  <= wb_dat_nxt;
            wb_irq_r  <= wb_irq_nxt;
        end
    end

    assign o_data            = data_r;
    assign o_data_oe         = data_oe_r;
    assign o_irq_n           = !irq_drv_r;  // Low only while driving
    assign o_irq_oe          = irq_drv_r;
    assign o_square_wave_out = sqw_r;
    assign o_wb_dat          = wb_dat_r;
    assign o_wb_ack          = ack_r;
    assign o_wb_irq          = wb_irq_r;

    rtcxp_mem #(.DEPTH(CLK_BANK_BYTES), .AW(6), .DW(8)) u_clk_mem (
        .i_clk (i_clk),
        .bus   (clk_mem.mem)
    );

    rtcxp_mem #(.DEPTH(PAGES * PAGE_BYTES), .AW(XAW), .DW(8)) u_ram_mem (
        .i_clk (i_clk),
        .bus   (ram_mem.mem)
    );
endmodule
